// ===== dv/chg_host_model.sv
// bus controller model that frames transfers on the two wires
`timescale 1ns/100ps
module chg_host_model (
  input  wire logic scl_w_i,
  input  wire logic sda_w_i,
  output logic      scl_pull_o,
  output logic      sda_pull_o
);
  localparam int QTR = 12; // quarter of the 48 ns link period

  // both lines released at time zero, bus idle high
  initial
  begin
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
  end

  // one clock pulse; data moves only while clock low, a stretch is waited out
  task automatic bit_io(input logic b, output logic r);
    #QTR sda_pull_o = ~b;
    #QTR scl_pull_o = 1'b0;
    wait (scl_w_i === 1'b1);
    #QTR r = sda_w_i;
    #QTR scl_pull_o = 1'b1;
  endtask

  // start or repeated start: data falls while clock high
  task automatic start();
    #QTR sda_pull_o = 1'b0;
    #QTR scl_pull_o = 1'b0;
    wait (scl_w_i === 1'b1);
    #QTR sda_pull_o = 1'b1;
    #QTR scl_pull_o = 1'b1;
  endtask

  // stop: data rises while clock high, then the clock stands still
  task automatic stop();
    #QTR sda_pull_o = 1'b1;
    #QTR scl_pull_o = 1'b0;
    wait (scl_w_i === 1'b1);
    #QTR sda_pull_o = 1'b0;
    #QTR;
  endtask

  // eight bits msb first then the ninth pulse; sending 1 releases the line
  task automatic xbyte(input logic [7:0] d, input logic ack_in,
                       output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r[i]);
    bit_io(ack_in, ack);
  endtask
endmodule

// ===== dv/chg_port_tb.sv
// self-checking bench for the charger target port
`timescale 1ns/100ps
module chg_port_tb;
  typedef struct { logic [7:0] idx; logic [7:0] wd; logic [7:0] ex; } chg_row_type;

  logic        clk_i    = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        scl_o, scl_oe_o, sda_o, sda_oe_o, int_n_o;
  logic        host_mode_o, stat_o, busy_o, f0_o, f1_o, f2_o;
  logic        scl_pull, sda_pull, scl_w, sda_w;
  logic [7:0]  r0, r1, rx;
  logic        a;
  int          err_count = 0;
  int          cmp_count = 0;
  int          low_cnt   = 0;
  chg_row_type rows [6] = '{'{8'h10, 8'h00, 8'h00}, '{8'h14, 8'h07, 8'h07},
                            '{8'h00, 8'ha5, 8'ha5}, '{8'h25, 8'h01, 8'h01},
                            '{8'h1b, 8'h01, 8'h00}, '{8'h10, 8'h04, 8'h00}};

  // open-drain wires: low when any party pulls
  assign scl_w = ~(scl_pull | scl_oe_o);
  assign sda_w = ~(sda_pull | sda_oe_o);

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  // short counts keep the timeout near 800 cycles
  chg_port #(.MS_CYC(20), .ALERT_CYC(16)) dut_u (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .int_n_o(int_n_o), .host_mode_o(host_mode_o), .host_timeout_status_o(stat_o),
    .bus_busy_o(busy_o), .forced_current_optimize_request_o(f0_o),
    .forced_port_detect_request_o(f1_o), .forced_input_voltage_measure_request_o(f2_o));

  chg_host_model host_u (
    .scl_w_i(scl_w), .sda_w_i(sda_w), .scl_pull_o(scl_pull), .sda_pull_o(sda_pull));

  // one compare for every kind of result, bits widened to a byte
  task automatic chk(input logic [7:0] got, input logic [7:0] ex);
    cmp_count++;
    if (got !== ex)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, ex);
    end
  endtask

  // start and address phase; direction bit last
  task automatic addr(input logic rd);
    host_u.start();
    host_u.xbyte({7'h6b, rd}, 1'b1, rx, a);
    chk({7'h0, a}, 8'h00);
  endtask

  // index then n data bytes; bytes past the last place are refused
  task automatic wr(input logic [7:0] idx, d0, d1, input int n, input logic inack);
    addr(1'b0);
    host_u.xbyte(idx, 1'b1, rx, a);
    chk({7'h0, a}, {7'h0, inack});
    for (int i = 0; i < n; i++)
    begin
      host_u.xbyte(i ? d1 : d0, 1'b1, rx, a);
      chk({7'h0, a}, {7'h0, (idx + i[7:0]) > 8'h25});
    end
    host_u.stop();
  endtask

  // index, repeated start, n bytes read, the last one refused
  task automatic rd(input logic [7:0] idx, input int n);
    addr(1'b0);
    host_u.xbyte(idx, 1'b1, rx, a);
    chk({7'h0, a}, 8'h00);
    addr(1'b1);
    for (int i = 0; i < n; i++)
    begin
      host_u.xbyte(8'hff, i == n - 1, rx, a);
      if (i == 0)
        r0 = rx;
      else
        r1 = rx;
    end
    host_u.stop();
  endtask

  // verdict, reached by the main sequence or by the watchdog
  task automatic test_done();
    $display("errors %0d, comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // hang guard, well beyond the expected 40 us
  initial
  begin
    #200us;
    err_count++;
    test_done();
  end

  initial
  begin
    repeat (5) @(negedge clk_i);
    chk({host_mode_o, stat_o}, 8'h01);
    chk({6'h00, scl_o, sda_o}, 8'h00);
    arst_n_i = 1'b1;
    // power-up alert: exactly one pulse of the shortened length
    repeat (40)
    begin
      @(negedge clk_i);
      low_cnt += (int_n_o === 1'b0);
    end
    chk(low_cnt[7:0], 8'h10);
    // ordinary write then read-back rows
    foreach (rows[k])
    begin
      wr(rows[k].idx, rows[k].wd, 8'h00, 1, 1'b0);
      rd(rows[k].idx, 1);
      chk(r0, rows[k].ex);
    end
    chk({host_mode_o, stat_o, f2_o, f1_o, f0_o}, 8'h17);
    // multi-byte write and read with index advance
    wr(8'h01, 8'h11, 8'h22, 2, 1'b0);
    rd(8'h01, 2);
    chk(r0, 8'h11);
    chk(r1, 8'h22);
    rd(8'h25, 2);
    chk(r1, 8'hff);
    wr(8'h25, 8'h00, 8'h33, 2, 1'b0);
    wr(8'h26, 8'h00, 8'h00, 0, 1'b1);
    // foreign address ignored; busy between start and stop
    host_u.start();
    host_u.xbyte({7'h6a, 1'b0}, 1'b1, rx, a);
    chk({6'h00, a, busy_o}, 8'h03);
    host_u.stop();
    repeat (4) @(negedge clk_i);
    chk({7'h0, busy_o}, 8'h00);
    // restore: defaults back, force requests dropped, timer restarted
    wr(8'h10, 8'h09, 8'h00, 1, 1'b0);
    chk({5'h0, f2_o, f1_o, f0_o}, 8'h00);
    rd(8'h10, 1);
    chk(r0, 8'h01);
    for (int i = 0; i < 2000 && stat_o !== 1'b1; i++)
      @(negedge clk_i);
    chk({host_mode_o, stat_o}, 8'h01);
    repeat (2) @(negedge clk_i);
    chk({7'h0, int_n_o}, 8'h00);
    rd(8'h1b, 1);
    chk(r0, 8'h01);
    rd(8'h22, 1);
    chk(r0, 8'h01);
    rd(8'h22, 1);
    chk(r0, 8'h00);
    test_done();
  end
endmodule

// ===== verilog/chg_params.svh
// constants for the charger two-wire target port and host-timeout logic
// Functional notes
// R1 - answer only target address 0x6B
// R2 - reads above 0x25 return 0xFF
// R3 - work at 100 and 400 kbit/s
// R4 - data changes only while clock low
// R5 - start/stop framing; busy between them
// R6 - eight-bit bytes, MSB first, unlimited count
// R7 - ninth pulse: receiver pulls data low
// R8 - hold clock low until ready
// R9 - controller follows NACK with stop/restart
// R10 - seven-bit address then direction bit
// R11 - single write: address, index, data, acked
// R12 - single read: index, restart, one byte
// R13 - undefined index: NACK, back to idle
// R14 - multi-byte reads and writes supported
// R15 - index advances after each data byte
// R16 - power-on: default mode, expired, defaults
// R17 - enter default: status, flag, alert
// R18 - flag reads once; status low in host
// R19 - any write enters host mode, starts timer
// R20 - host kicks timer or disables with 00
// R21 - expiry: default mode, registers reset, alert
// R22 - restore bit resets registers, self-clears
// R23 - restore clears the three force requests
// R24 - alert is 256us low pulse; flags clear
`ifndef CHG_PARAMS_SVH
`define CHG_PARAMS_SVH

`define CHG_TARGET_ADDR      7'h6b
`define CHG_LAST_IDX         8'h25
`define CHG_NREGS            38
`define CHG_RD_BEYOND        8'hff

// locations of the control and status bits
`define CHG_CTRL_IDX         8'h10
`define CHG_CTRL_RST         8'h01
`define CHG_PERIOD_LSB       0
`define CHG_KICK_BIT         2
`define CHG_RESTORE_BIT      3
`define CHG_FORCE_IDX        8'h14
`define CHG_STATUS_IDX       8'h1b
`define CHG_FLAG_IDX         8'h22
`define CHG_MASK_IDX         8'h25

// host-timeout periods in milliseconds per period code
`define CHG_WD_MS_1          8'h28
`define CHG_WD_MS_2          8'h50
`define CHG_WD_MS_3          8'ha0

// timing
`define CHG_CLK_NS           5
`define CHG_MS_NS            1000000
`define CHG_ALERT_US         256
`define CHG_MS_CYC           (`CHG_MS_NS / `CHG_CLK_NS)
`define CHG_ALERT_CYC        ((`CHG_ALERT_US * 1000) / `CHG_CLK_NS)
`define CHG_STRETCH_LAST     2'h2

`endif

// ===== verilog/chg_pkg.sv
// types shared by the charger target port and its register store
`include "chg_params.svh"
package chg_pkg;

  // bus engine states
  typedef enum logic [3:0] {
    CHG_ST_IDLE   = 4'b0000,
    CHG_ST_ADDR   = 4'b0001,
    CHG_ST_IDX    = 4'b0010,
    CHG_ST_WDATA  = 4'b0011,
    CHG_ST_ACK_A  = 4'b0100,
    CHG_ST_ACK_RX = 4'b0101,
    CHG_ST_HOLD   = 4'b0110,
    CHG_ST_TX     = 4'b0111,
    CHG_ST_TX_ACK = 4'b1000
  } chg_state_type;

  // all state of the port engine
  typedef struct packed {
    chg_state_type st;
    logic          scl_s1;
    logic          scl_s2;
    logic          scl_d;
    logic          sda_s1;
    logic          sda_s2;
    logic          sda_d;
    logic [3:0]    bit_cnt;
    logic [7:0]    shreg;
    logic [7:0]    ptr;
    logic          rw;
    logic          busy;
    logic          sda_oe;
    logic          scl_oe;
    logic [1:0]    hold_cnt;
    logic          dflt_mode;
    logic          to_flag;
    logic          alert_pend;
    logic          int_act;
    logic [15:0]   int_cnt;
    logic [17:0]   ms_div;
    logic [7:0]    wd_ms;
  } chg_main_type;

  // register store image
  typedef struct packed {
    logic [`CHG_NREGS-1:0][7:0] mem;
  } chg_regs_type;

endpackage

// ===== verilog/chg_port.sv
// two-wire target port of the charger with host-timeout and restore control
`timescale 1ns/100ps
`include "chg_params.svh"
module chg_port #(
  parameter int unsigned MS_CYC    = `CHG_MS_CYC,    // cycles per millisecond tick
  parameter int unsigned ALERT_CYC = `CHG_ALERT_CYC  // alert pulse length in cycles
) (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic scl_i,
  output logic      scl_o,
  output logic      scl_oe_o,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  output logic      int_n_o,
  output logic      host_mode_o,
  output logic      host_timeout_status_o,
  output logic      bus_busy_o,
  output logic      forced_current_optimize_request_o,
  output logic      forced_port_detect_request_o,
  output logic      forced_input_voltage_measure_request_o
);
  import chg_pkg::*;

  // power-on image: default mode, timer expired, alert pending
  localparam chg_main_type MAIN_RST = '{
    st: CHG_ST_IDLE, scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
    sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1, bit_cnt: 4'h0,
    shreg: 8'h00, ptr: 8'h00, rw: 1'b0, busy: 1'b0, sda_oe: 1'b0,
    scl_oe: 1'b0, hold_cnt: 2'h0, dflt_mode: 1'b1, to_flag: 1'b1,
    alert_pend: 1'b1, int_act: 1'b0, int_cnt: 16'h0000,
    ms_div: 18'h0_0000, wd_ms: 8'h00};

  chg_main_type s_r;    // engine state
  chg_main_type s_nxt;  // next engine state

  logic       scl_rise;  // clock edge seen on synchronised line
  logic       scl_fall;
  logic       start_ev;  // start or repeated start
  logic       stop_ev;
  logic       reg_we;    // byte write into the store
  logic [7:0] reg_wd;
  logic       reg_dflt;  // restore to defaults
  logic [7:0] store_rd;  // raw byte at the pointer
  logic [7:0] rd_byte;   // byte with live status overlaid
  logic [1:0] period;
  logic [2:0] force_req;
  logic       to_mask;
  logic       expire_ev; // host timeout ran out this cycle
  logic       tick;      // one-millisecond enable

  // timeout limit in ms for a period code; zero means off
  function automatic logic [7:0] wd_limit(input logic [1:0] code);
    case (code)
      2'h1:    wd_limit = `CHG_WD_MS_1;
      2'h2:    wd_limit = `CHG_WD_MS_2;
      2'h3:    wd_limit = `CHG_WD_MS_3;
      default: wd_limit = 8'h00;
    endcase
  endfunction

  // edges from the second and third stages only
  assign scl_rise = s_r.scl_s2 & ~s_r.scl_d;
  assign scl_fall = ~s_r.scl_s2 & s_r.scl_d;
  assign start_ev = s_r.scl_s2 & s_r.scl_d & s_r.sda_d & ~s_r.sda_s2; // see R5
  assign stop_ev  = s_r.scl_s2 & s_r.scl_d & ~s_r.sda_d & s_r.sda_s2; // see R5
  assign tick     = (s_r.ms_div == 18'(MS_CYC - 1));

  // status and flag bits live here, not in the store
  always_comb
  begin
    rd_byte = store_rd;
    if (s_r.ptr == `CHG_STATUS_IDX)
    begin
      rd_byte[0] = s_r.dflt_mode; // see R18
    end
    if (s_r.ptr == `CHG_FLAG_IDX)
    begin
      rd_byte[0] = s_r.to_flag;
    end
  end

  // engine, timeout and alert next-state logic
  always_comb
  begin
    s_nxt     = s_r;
    reg_we    = 1'b0;
    reg_wd    = 8'h00;
    reg_dflt  = 1'b0;
    expire_ev = 1'b0;
    // two-stage synchronisers, third stage for edges
    s_nxt.scl_s1 = scl_i; // see R3
    s_nxt.scl_s2 = s_r.scl_s1;
    s_nxt.scl_d  = s_r.scl_s2;
    s_nxt.sda_s1 = sda_i;
    s_nxt.sda_s2 = s_r.sda_s1;
    s_nxt.sda_d  = s_r.sda_s2;

    if (start_ev)
    begin
      // a restart drops whatever was in flight
      s_nxt.st      = CHG_ST_ADDR;
      s_nxt.bit_cnt = 4'h0;
      s_nxt.busy    = 1'b1;
      s_nxt.sda_oe  = 1'b0;
      s_nxt.scl_oe  = 1'b0;
    end
    else if (stop_ev)
    begin
      s_nxt.st     = CHG_ST_IDLE;
      s_nxt.busy   = 1'b0;
      s_nxt.sda_oe = 1'b0;
      s_nxt.scl_oe = 1'b0;
    end
    else
    begin
      case (s_r.st)
        CHG_ST_ADDR, CHG_ST_IDX, CHG_ST_WDATA:
        begin
          // sample on the rising edge, MSB first
          if (scl_rise)
          begin
            s_nxt.shreg   = {s_r.shreg[6:0], s_r.sda_s2}; // see R6
            s_nxt.bit_cnt = 4'(s_r.bit_cnt + 4'h1);
          end
          else if (scl_fall && s_r.bit_cnt == 4'h8)
          begin
            s_nxt.bit_cnt = 4'h0;
            s_nxt.st      = CHG_ST_IDLE;
            if (s_r.st == CHG_ST_ADDR)
            begin
              // other targets are left alone, bus stays busy
              if (s_r.shreg[7:1] == `CHG_TARGET_ADDR) // see R1, R10
              begin
                s_nxt.rw     = s_r.shreg[0];
                s_nxt.sda_oe = 1'b1; // see R7
                s_nxt.st     = CHG_ST_ACK_A;
              end
            end
            else if (s_r.st == CHG_ST_IDX)
            begin
              // undefined index: no ack, idle again
              if (s_r.shreg <= `CHG_LAST_IDX) // see R13
              begin
                s_nxt.ptr    = s_r.shreg;
                s_nxt.sda_oe = 1'b1;
                s_nxt.st     = CHG_ST_ACK_RX;
              end
            end
            else if (s_r.ptr <= `CHG_LAST_IDX)
            begin
              // data byte: store it and step on
              reg_we       = 1'b1; // see R11, R14
              reg_wd       = s_r.shreg;
              s_nxt.ptr    = 8'(s_r.ptr + 8'h01); // see R15
              s_nxt.sda_oe = 1'b1;
              s_nxt.st     = CHG_ST_ACK_RX;
              if (s_r.ptr == `CHG_CTRL_IDX)
              begin
                // kick and restore never stay set
                reg_wd[`CHG_KICK_BIT]    = 1'b0;
                reg_wd[`CHG_RESTORE_BIT] = 1'b0; // see R22
                reg_dflt = s_r.shreg[`CHG_RESTORE_BIT];
              end
            end
          end
        end
        CHG_ST_ACK_A:
        begin
          // release after the ninth pulse; reads stretch first
          if (scl_fall)
          begin
            s_nxt.sda_oe = 1'b0;
            if (s_r.rw)
            begin
              s_nxt.st       = CHG_ST_HOLD; // see R12
              s_nxt.scl_oe   = 1'b1;
              s_nxt.hold_cnt = 2'h0;
            end
            else
            begin
              s_nxt.st = CHG_ST_IDX;
            end
          end
        end
        CHG_ST_ACK_RX:
        begin
          if (scl_fall)
          begin
            s_nxt.sda_oe = 1'b0;
            s_nxt.st     = CHG_ST_WDATA;
          end
        end
        CHG_ST_HOLD:
        begin
          // clock held low while the next byte is fetched
          s_nxt.hold_cnt = 2'(s_r.hold_cnt + 2'h1);
          if (s_r.hold_cnt == 2'h0)
          begin
            s_nxt.shreg = rd_byte;
            // flag reads once, then clears
            if (s_r.ptr == `CHG_FLAG_IDX)
            begin
              s_nxt.to_flag = 1'b0; // see R18, R24
            end
          end
          if (s_r.hold_cnt == 2'h1)
          begin
            // first bit settles a cycle before the clock is let go
            s_nxt.sda_oe = ~s_r.shreg[7]; // see R4
          end
          if (s_r.hold_cnt == `CHG_STRETCH_LAST)
          begin
            s_nxt.scl_oe  = 1'b0; // see R8
            s_nxt.bit_cnt = 4'h0;
            s_nxt.st      = CHG_ST_TX;
          end
        end
        CHG_ST_TX:
        begin
          // new bit only after the clock has fallen
          if (scl_fall)
          begin
            s_nxt.bit_cnt = 4'(s_r.bit_cnt + 4'h1);
            if (s_r.bit_cnt == 4'h7)
            begin
              s_nxt.sda_oe = 1'b0; // see R7
              s_nxt.st     = CHG_ST_TX_ACK;
            end
            else
            begin
              s_nxt.shreg  = {s_r.shreg[6:0], 1'b0}; // see R4
              s_nxt.sda_oe = ~s_r.shreg[6];
            end
          end
        end
        CHG_ST_TX_ACK:
        begin
          // bit_cnt reused to remember the controller ack
          if (scl_rise)
          begin
            s_nxt.ptr     = 8'(s_r.ptr + 8'h01); // see R15
            s_nxt.bit_cnt = {3'h0, ~s_r.sda_s2};
          end
          else if (scl_fall)
          begin
            if (s_r.bit_cnt[0])
            begin
              s_nxt.st       = CHG_ST_HOLD; // see R14
              s_nxt.scl_oe   = 1'b1;
              s_nxt.hold_cnt = 2'h0;
            end
            else
            begin
              // nack: wait for the stop or restart
              s_nxt.st = CHG_ST_IDLE; // see R9
            end
          end
        end
        CHG_ST_IDLE:
        begin
          s_nxt.sda_oe = 1'b0;
        end
        default:
        begin
          s_nxt.st = CHG_ST_IDLE;
        end
      endcase
    end

    // millisecond divider free-runs; cheaper than per-period counters
    s_nxt.ms_div = tick ? 18'h0_0000 : 18'(s_r.ms_div + 18'h0_0001);

    // host timeout counts only in host mode with a nonzero period
    if (reg_we)
    begin
      // a write leaves default mode and restarts a stopped timer
      if (s_r.dflt_mode || reg_dflt)
      begin
        s_nxt.wd_ms = 8'h00; // see R19, R22
      end
      s_nxt.dflt_mode = 1'b0; // see R19
      if (s_r.ptr == `CHG_CTRL_IDX && s_r.shreg[`CHG_KICK_BIT])
      begin
        s_nxt.wd_ms = 8'h00; // see R20
      end
    end
    else if (!s_r.dflt_mode && wd_limit(period) != 8'h00 && tick)
    begin
      if (8'(s_r.wd_ms + 8'h01) >= wd_limit(period))
      begin
        expire_ev        = 1'b1;
        reg_dflt         = 1'b1; // see R21
        s_nxt.dflt_mode  = 1'b1;
        s_nxt.to_flag    = 1'b1; // see R17
        s_nxt.alert_pend = 1'b1;
        s_nxt.wd_ms      = 8'h00;
      end
      else
      begin
        s_nxt.wd_ms = 8'(s_r.wd_ms + 8'h01);
      end
    end

    // alert pulse; a masked event is simply dropped
    if (s_r.int_act)
    begin
      s_nxt.int_cnt = 16'(s_r.int_cnt + 16'h0001);
      if (s_r.int_cnt == 16'(ALERT_CYC - 1))
      begin
        s_nxt.int_act = 1'b0; // see R24
      end
    end
    else if (s_r.alert_pend)
    begin
      s_nxt.alert_pend = expire_ev;
      s_nxt.int_act    = ~to_mask; // see R17
      s_nxt.int_cnt    = 16'h0000;
    end
  end

  // single state register
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_r <= MAIN_RST; // see R16
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // register store
  chg_regs u_regs (
    .clk_i     (clk_i),
    .arst_n_i  (arst_n_i),
    .we_i      (reg_we),
    .idx_i     (s_r.ptr),
    .wdata_i   (reg_wd),
    .dflt_i    (reg_dflt),
    .rd_idx_i  (s_r.ptr),
    .rd_data_o (store_rd),
    .period_o  (period),
    .force_o   (force_req),
    .mask_o    (to_mask)
  );

  // open-drain lines only ever pull low
  assign scl_o                                  = 1'b0;
  assign sda_o                                  = 1'b0;
  assign scl_oe_o                               = s_r.scl_oe;
  assign sda_oe_o                               = s_r.sda_oe;
  assign int_n_o                                = ~s_r.int_act;
  assign host_mode_o                            = ~s_r.dflt_mode;
  assign host_timeout_status_o                  = s_r.dflt_mode;
  assign bus_busy_o                             = s_r.busy;
  assign forced_current_optimize_request_o      = force_req[0];
  assign forced_port_detect_request_o           = force_req[1];
  assign forced_input_voltage_measure_request_o = force_req[2];

  // checks on the port engine
  a_addr_ignore: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see R1
    (s_r.st == CHG_ST_ADDR && scl_fall && s_r.bit_cnt == 4'h8 && !start_ev && !stop_ev
     && s_r.shreg[7:1] != `CHG_TARGET_ADDR) |=> (s_r.st == CHG_ST_IDLE && !s_r.sda_oe))
    else $error("foreign address was answered");
  a_rd_beyond: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see R2
    (s_r.ptr > `CHG_LAST_IDX) |-> (rd_byte == `CHG_RD_BEYOND))
    else $error("read past map not 0xff");
  a_sda_low_clk: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see R4
    ($changed(s_r.sda_oe) && !$past(start_ev) && !$past(stop_ev)) |-> !$past(s_r.scl_s2))
    else $error("data drive changed while clock high");
  a_busy_frame: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see R5
    (start_ev |=> s_r.busy) and (stop_ev |=> !s_r.busy))
    else $error("busy does not follow start and stop");
  a_ack_held: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see R7
    ((s_r.st == CHG_ST_ACK_A || s_r.st == CHG_ST_ACK_RX) && !scl_fall
     && !start_ev && !stop_ev) |=> s_r.sda_oe)
    else $error("ack released early");
  a_stretch_len: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see R8
    ($rose(s_r.scl_oe) && !$past(start_ev) && !$past(stop_ev) && !start_ev && !stop_ev)
    |-> s_r.scl_oe[*3] ##1 !s_r.scl_oe)
    else $error("clock stretch length wrong");
  a_nack_idx: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see R13
    (s_r.st == CHG_ST_IDX && scl_fall && s_r.bit_cnt == 4'h8 && !start_ev && !stop_ev
     && s_r.shreg > `CHG_LAST_IDX) |=> (s_r.st == CHG_ST_IDLE && !s_r.sda_oe))
    else $error("undefined index acknowledged");
  a_ptr_step: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see R15
    (s_r.st == CHG_ST_TX_ACK && scl_rise && !start_ev && !stop_ev)
    |=> s_r.ptr == 8'($past(s_r.ptr) + 8'h01))
    else $error("index did not advance after read byte");
  a_flag_once: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see R18
    $fell(s_r.to_flag) |-> ($past(s_r.st) == CHG_ST_HOLD && $past(s_r.ptr) == `CHG_FLAG_IDX))
    else $error("flag cleared without a read");
  a_host_write: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see R19
    reg_we |=> host_mode_o && !host_timeout_status_o)
    else $error("write did not enter host mode");
  a_expire: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see R21
    expire_ev |=> (s_r.dflt_mode && s_r.to_flag && force_req == 3'h0))
    else $error("expiry did not restore default mode");
  a_alert_len: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see R24
    (s_r.int_act && s_r.int_cnt == 16'(ALERT_CYC - 1)) |=> int_n_o)
    else $error("alert pulse length wrong");
  a_restore: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see R23
    reg_dflt |=> force_req == 3'h0)
    else $error("restore left a force request set");

  c_write: cover property (@(posedge clk_i) disable iff (!arst_n_i) reg_we);
  c_read: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    s_r.st == CHG_ST_TX_ACK && scl_fall);
  c_expire: cover property (@(posedge clk_i) disable iff (!arst_n_i) expire_ev);

endmodule

// ===== verilog/chg_regs.sv
// register store with default restore and out-of-range read answer
`timescale 1ns/100ps
`include "chg_params.svh"
module chg_regs #(
  parameter logic [`CHG_NREGS-1:0] EXEMPT = '0
) (
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       we_i,
  input  wire logic [7:0] idx_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       dflt_i,
  input  wire logic [7:0] rd_idx_i,
  output logic      [7:0] rd_data_o,
  output logic      [1:0] period_o,
  output logic      [2:0] force_o,
  output logic            mask_o
);
  import chg_pkg::*;

  // default value of one location
  function automatic logic [7:0] dflt_of(input int i);
    dflt_of = (i == int'(`CHG_CTRL_IDX)) ? `CHG_CTRL_RST : 8'h00;
  endfunction

  // whole image after power-on
  function automatic chg_regs_type rst_image();
    chg_regs_type r;
    for (int i = 0; i < `CHG_NREGS; i++)
    begin
      r.mem[i] = dflt_of(i);
    end
    return r;
  endfunction

  localparam chg_regs_type REGS_RST = rst_image();

  chg_regs_type regs_r;   // stored bytes
  chg_regs_type regs_nxt; // next image

  // write first, then restore overrides every non-exempt byte
  always_comb
  begin
    regs_nxt = regs_r;
    if (we_i && idx_i <= `CHG_LAST_IDX)
    begin
      regs_nxt.mem[idx_i[5:0]] = wdata_i;
    end
    if (dflt_i)
    begin
      for (int i = 0; i < `CHG_NREGS; i++)
      begin
        if (!EXEMPT[i])
        begin
          regs_nxt.mem[i] = dflt_of(i);
        end
      end
      // force requests end even if their byte were exempt
      regs_nxt.mem[`CHG_FORCE_IDX][2:0] = 3'h0; // see R23
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      regs_r <= REGS_RST; // see R16
    end
    else
    begin
      regs_r <= regs_nxt;
    end
  end

  // locations past the map answer a fixed byte
  assign rd_data_o = (rd_idx_i > `CHG_LAST_IDX) ? `CHG_RD_BEYOND
                                               : regs_r.mem[rd_idx_i[5:0]]; // see R2
  assign period_o  = regs_r.mem[`CHG_CTRL_IDX][`CHG_PERIOD_LSB +: 2];
  assign force_o   = regs_r.mem[`CHG_FORCE_IDX][2:0];
  assign mask_o    = regs_r.mem[`CHG_MASK_IDX][0];

endmodule
